// ### hdl/dmr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module dmr_regs
  import dmr_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              cpu_reset_instr,
  input  wire logic              acc_valid,
  input  wire logic              acc_write,
  input  wire logic              acc_super,
  input  wire logic [ADDR_W-1:0] acc_addr,
  input  wire logic [1:0]        acc_byte_en,
  input  wire logic [15:0]       acc_wdata,
  output logic                   acc_done,
  output logic                   acc_berr,
  output logic [15:0]            acc_rdata,
  output logic                   module_clk_en,
  output logic [1:0]             su_access_ok,
  input  wire logic              freeze,
  input  wire logic              bus_cycle_active,
  input  wire logic              bus_cycle_end,
  input  wire logic [2:0]        bus_irq_level,
  input  wire logic [2:0]        cpu_priority_mask,
  input  wire logic [1:0]        ch_bus_req,
  output logic [1:0]             ch_start_ok,
  output logic                   bus_request_line,
  output logic                   grant_ch2,
  input  wire logic [1:0]        ch_single_addr,
  input  wire logic              data_drive_req,
  output logic                   data_bus_oe,
  input  wire logic [1:0]        ch_irq_pending,
  output logic [7:1]             irq_lines,
  input  wire logic              iack_valid,
  input  wire logic [2:0]        iack_level,
  input  wire logic              iack_win,
  output logic                   iack_compete,
  output logic [3:0]             iack_arb_id,
  output logic                   iack_vec_valid,
  output logic [7:0]             iack_vector
);

  initial
  begin
    if (ADDR_W < 12)
      $error("dmr_regs: ADDR_W must be at least 12");
  end

  typedef struct packed {
    logic            halt;
    logic [1:0]      frz;
    logic [3:0]      irq_arbitration_id;
    logic [1:0]      sadrv;
    logic [1:0][2:0] service_mask_level;
    logic [1:0]      priv;
    logic [1:0][2:0] master_priority_id;
    logic [1:0][2:0] lvl;
    logic [1:0][7:0] vec;
    logic            frozen;
    logic            gnt2;
    logic            done;
    logic            berr;
    logic [15:0]     rdata;
    logic            vvalid;
    logic [7:0]      vout;
  } dmr_state_type;

  dmr_state_type st_r;
  dmr_state_type st_nxt;

  logic [11:0] ofs;
  logic        in_win;
  logic        hit_cfg;
  logic        hit_irq;
  logic        hit_rsv;
  logic        ch_sel;
  logic [15:0] cfg_view;
  logic [15:0] irq_view;
  logic [15:0] wmask;
  logic [15:0] cfg_new;
  logic [15:0] irq_new;
  logic [1:0]  elig;
  logic        pick2;
  logic        frz_on;
  logic        can_stop;
  logic        act_single;
  logic        hit1;
  logic        hit2;

  // Byte lane 1 is bits 15:8 and lane 0 is bits 7:0; bit 0 of the address is ignored.
  assign ofs     = {acc_addr[11:1], 1'b0};
  assign in_win  = (acc_addr[11:DMR_WIN_LSB] == DMR_WIN_TAG);
  assign hit_cfg = (ofs == DMR_OFS_CFG_CH1) || (ofs == DMR_OFS_CFG_CH2);
  assign hit_irq = (ofs == DMR_OFS_IRQ_CH1) || (ofs == DMR_OFS_IRQ_CH2);
  assign hit_rsv = (ofs == DMR_OFS_RSV_CH1) || (ofs == DMR_OFS_RSV_CH2);
  assign ch_sel  = (ofs == DMR_OFS_CFG_CH2) || (ofs == DMR_OFS_IRQ_CH2)
                 || (ofs == DMR_OFS_RSV_CH2);
  assign wmask   = {{8{acc_byte_en[1]}}, {8{acc_byte_en[0]}}};

  // Shared fields appear in both channel views from one store.
  always_comb
  begin
    cfg_view = DMR_ZERO16;
    cfg_view[DMR_CFG_HALT] = st_r.halt;
    cfg_view[DMR_CFG_FRZ_HI] = st_r.frz[1];
    cfg_view[DMR_CFG_FRZ_LO] = st_r.frz[0];
    cfg_view[DMR_CFG_SADRV] = st_r.sadrv[ch_sel];
    cfg_view[DMR_CFG_ISM_LO +: 3] = st_r.service_mask_level[ch_sel];
    cfg_view[DMR_CFG_PRIV] = st_r.priv[ch_sel];
    cfg_view[DMR_CFG_MASTER_PRIORITY_ID_LO +: 3] = st_r.master_priority_id[ch_sel];
    cfg_view[DMR_CFG_IRQ_ARBITRATION_ID_LO +: 4] = st_r.irq_arbitration_id;
    irq_view = DMR_ZERO16;
    irq_view[DMR_IRQ_LVL_LO +: 3] = st_r.lvl[ch_sel];
    irq_view[DMR_IRQ_VEC_LO +: 8] = st_r.vec[ch_sel];
  end

  assign cfg_new = (cfg_view & ~wmask) | (acc_wdata & wmask);
  assign irq_new = (irq_view & ~wmask) | (acc_wdata & wmask);

  // Eligible requests: a channel must not hold the bus while the bus level is above its mask.
  assign elig[0] = ch_bus_req[0] && (bus_irq_level <= st_r.service_mask_level[0]);
  assign elig[1] = ch_bus_req[1] && (bus_irq_level <= st_r.service_mask_level[1]);
  // Channel 2 wins only with a strictly higher priority or when channel 1 is absent.
  assign pick2 = elig[1] && (!elig[0] || (st_r.master_priority_id[1] > st_r.master_priority_id[0]));

  assign frz_on   = freeze && (st_r.frz == DMR_FRZ_BOUNDARY);
  // A stop is allowed between cycles or as the current cycle ends.
  assign can_stop = !bus_cycle_active || bus_cycle_end;

  assign hit1 = iack_valid && ch_irq_pending[0]
             && (st_r.lvl[0] == iack_level) && (iack_level != DMR_LVL_NONE);
  assign hit2 = iack_valid && ch_irq_pending[1]
             && (st_r.lvl[1] == iack_level) && (iack_level != DMR_LVL_NONE);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.berr = 1'b0;
    st_nxt.vvalid = 1'b0;

    if (acc_valid && in_win)
    begin
      if (hit_cfg)
      begin
        // Configuration stays reachable in stop mode so software can wake the module.
        if (!acc_super)
          st_nxt.berr = 1'b1;
        else
        begin
          st_nxt.done = 1'b1;
          if (acc_write)
          begin
            st_nxt.halt = cfg_new[DMR_CFG_HALT];
            st_nxt.frz = {cfg_new[DMR_CFG_FRZ_HI], cfg_new[DMR_CFG_FRZ_LO]};
            st_nxt.sadrv[ch_sel] = cfg_new[DMR_CFG_SADRV];
            st_nxt.service_mask_level[ch_sel] = cfg_new[DMR_CFG_ISM_LO +: 3];
            st_nxt.priv[ch_sel] = cfg_new[DMR_CFG_PRIV];
            st_nxt.master_priority_id[ch_sel] = cfg_new[DMR_CFG_MASTER_PRIORITY_ID_LO +: 3];
            st_nxt.irq_arbitration_id = cfg_new[DMR_CFG_IRQ_ARBITRATION_ID_LO +: 4];
          end
          else
            st_nxt.rdata = cfg_view;
        end
      end
      else if (st_r.halt)
        st_nxt.berr = 1'b1;
      else if (hit_irq || hit_rsv)
      begin
        if (!acc_super)
          st_nxt.berr = 1'b1;
        else
        begin
          st_nxt.done = 1'b1;
          if (acc_write && hit_irq)
          begin
            st_nxt.lvl[ch_sel] = irq_new[DMR_IRQ_LVL_LO +: 3];
            st_nxt.vec[ch_sel] = irq_new[DMR_IRQ_VEC_LO +: 8];
          end
          else if (!acc_write)
            st_nxt.rdata = hit_irq ? irq_view : DMR_ZERO16;
        end
      end
    end

    // Freeze waits for a cycle boundary and lasts while the freeze input stays high.
    if (!freeze)
      st_nxt.frozen = 1'b0;
    else if (frz_on && can_stop)
      st_nxt.frozen = 1'b1;

    // Mastership is held through a running cycle; only the reset instruction clears the grant before the transfer ends.
    if (!bus_cycle_active || bus_cycle_end)
      st_nxt.gnt2 = pick2;

    if ((hit1 || hit2) && iack_win && (st_r.irq_arbitration_id != DMR_IRQ_ARBITRATION_ID_RST))
    begin
      st_nxt.vvalid = 1'b1;
      st_nxt.vout = hit1 ? st_r.vec[0] : st_r.vec[1];
    end

    // The reset instruction clears interrupt setup, freeze, grant and vector state; configuration fields, access replies and read data keep their values.
    if (cpu_reset_instr)
    begin
      st_nxt.lvl = {2{DMR_LVL_RST}};
      st_nxt.vec = {2{DMR_VEC_RST}};
      st_nxt.frozen = 1'b0;
      st_nxt.gnt2 = 1'b0;
      st_nxt.vvalid = 1'b0;
      st_nxt.vout = DMR_VEC_RST;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r.halt <= DMR_HALT_RST;
      st_r.frz <= DMR_FRZ_RST;
      st_r.irq_arbitration_id <= DMR_IRQ_ARBITRATION_ID_RST;
      st_r.sadrv <= {2{DMR_SE_RST}};
      st_r.service_mask_level <= {2{DMR_ISM_RST}};
      st_r.priv <= {2{DMR_PRIV_RST}};
      st_r.master_priority_id <= {2{DMR_MASTER_PRIORITY_ID_RST}};
      st_r.lvl <= {2{DMR_LVL_RST}};
      st_r.vec <= {2{DMR_VEC_RST}};
      st_r.frozen <= 1'b0;
      st_r.gnt2 <= 1'b0;
      st_r.done <= 1'b0;
      st_r.berr <= 1'b0;
      st_r.rdata <= DMR_ZERO16;
      st_r.vvalid <= 1'b0;
      st_r.vout <= DMR_VEC_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign acc_done  = st_r.done;
  assign acc_berr  = st_r.berr;
  assign acc_rdata = st_r.rdata;

  // The enable drops as a whole cycle, which matches stopping on the low phase.
  assign module_clk_en = !st_r.halt;

  // Shared channel registers open to user code only while privilege select is low.
  assign su_access_ok[0] = acc_super || !st_r.priv[0];
  assign su_access_ok[1] = acc_super || !st_r.priv[1];

  assign ch_start_ok[0] = (cpu_priority_mask <= st_r.service_mask_level[0]) && !st_r.halt;
  assign ch_start_ok[1] = (cpu_priority_mask <= st_r.service_mask_level[1]) && !st_r.halt;

  // Freeze is also honoured combinationally so the request drops in the boundary cycle.
  assign bus_request_line = (|elig) && !st_r.halt && !st_r.frozen
                          && !(frz_on && can_stop);
  assign grant_ch2 = st_r.gnt2;

  // The active channel is the granted one.
  assign act_single  = ch_single_addr[st_r.gnt2];
  assign data_bus_oe = data_drive_req
                     && (!act_single || st_r.sadrv[st_r.gnt2]);

  genvar g;
  generate
    for (g = 1; g <= 7; g++)
    begin : g_irq
      assign irq_lines[g] = (ch_irq_pending[0] && (st_r.lvl[0] == 3'(g)))
                         || (ch_irq_pending[1] && (st_r.lvl[1] == 3'(g)));
    end
  endgenerate

  assign iack_compete   = (hit1 || hit2) && (st_r.irq_arbitration_id != DMR_IRQ_ARBITRATION_ID_RST);
  assign iack_arb_id    = st_r.irq_arbitration_id;
  assign iack_vec_valid = st_r.vvalid;
  assign iack_vector    = st_r.vout;

endmodule // dmr_regs
`default_nettype wire

// ### hdl/dmr_pkg.sv
package dmr_pkg;

  // Register offsets within the module space.
  localparam logic [11:0] DMR_OFS_CFG_CH1 = 12'h780;
  localparam logic [11:0] DMR_OFS_IRQ_CH1 = 12'h784;
  localparam logic [11:0] DMR_OFS_CFG_CH2 = 12'h7A0;
  localparam logic [11:0] DMR_OFS_IRQ_CH2 = 12'h7A4;
  localparam logic [11:0] DMR_OFS_RSV_CH1 = 12'h782;
  localparam logic [11:0] DMR_OFS_RSV_CH2 = 12'h7A2;
  // Whole module window is 12'h780 to 12'h7BF.
  localparam int          DMR_WIN_LSB     = 6;
  localparam logic [5:0]  DMR_WIN_TAG     = 6'h1E;

  // Module configuration field positions.
  localparam int DMR_CFG_HALT   = 15;
  localparam int DMR_CFG_FRZ_HI = 14;
  localparam int DMR_CFG_FRZ_LO = 13;
  localparam int DMR_CFG_SADRV  = 12;
  localparam int DMR_CFG_ISM_LO = 8;
  localparam int DMR_CFG_PRIV   = 7;
  localparam int DMR_CFG_MASTER_PRIORITY_ID_LO = 4;
  localparam int DMR_CFG_IRQ_ARBITRATION_ID_LO = 0;

  // Interrupt setup field positions.
  localparam int DMR_IRQ_LVL_LO = 8;
  localparam int DMR_IRQ_VEC_LO = 0;

  // Freeze response encodings.
  localparam logic [1:0] DMR_FRZ_IGNORE   = 2'h0;
  localparam logic [1:0] DMR_FRZ_BOUNDARY = 2'h2;

  // Reset values.
  localparam logic [7:0] DMR_VEC_RST  = 8'h0F;
  localparam logic [2:0] DMR_LVL_RST  = 3'h0;
  localparam logic [3:0] DMR_IRQ_ARBITRATION_ID_RST = 4'h0;
  localparam logic [2:0] DMR_ISM_RST  = 3'h0;
  localparam logic [2:0] DMR_MASTER_PRIORITY_ID_RST = 3'h0;
  localparam logic       DMR_PRIV_RST = 1'b1;
  localparam logic       DMR_SE_RST   = 1'b0;
  localparam logic [1:0] DMR_FRZ_RST  = 2'h0;
  localparam logic       DMR_HALT_RST = 1'b0;

  localparam logic [15:0] DMR_ZERO16 = 16'h0000;
  localparam logic [2:0]  DMR_LVL_NONE = 3'h0;

endpackage : dmr_pkg

// ### verification/dmr_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dmr_regs_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        acc_valid,
  input wire logic        acc_super,
  input wire logic [11:0] acc_addr,
  input wire logic        acc_done,
  input wire logic        acc_berr,
  input wire logic        module_clk_en,
  input wire logic [1:0]  ch_bus_req,
  input wire logic [1:0]  ch_start_ok,
  input wire logic        bus_request_line,
  input wire logic        iack_valid,
  input wire logic        iack_compete,
  input wire logic        iack_vec_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  user_cfg_berr_a: assert property (acc_valid && !acc_super && acc_addr == 12'h780
    |=> acc_berr && !acc_done) else $error("user config access not refused");
  sup_cfg_ok_a: assert property (acc_valid && acc_super && acc_addr inside {12'h780, 12'h7A0}
    |=> acc_done) else $error("supervisor config access refused");
  irq_setup_ok_a: assert property (acc_valid && acc_super && module_clk_en && acc_addr == 12'h784
    |=> acc_done) else $error("irq setup access refused");
  halt_berr_a: assert property (acc_valid && !module_clk_en && acc_addr == 12'h784
    |=> acc_berr) else $error("access while halted not refused");
  halt_quiet_a: assert property (!module_clk_en |-> ch_start_ok == 2'b00 && !bus_request_line)
    else $error("halted module still active");
  answer_cause_a: assert property (acc_done || acc_berr |-> $past(acc_valid))
    else $error("answer without access");
  idle_no_req_a: assert property (ch_bus_req == 2'b00 |-> !bus_request_line)
    else $error("bus request without channel request");
  vec_cause_a: assert property (iack_vec_valid |-> $past(iack_valid && iack_compete))
    else $error("vector without won acknowledge");
endmodule // dmr_regs_chk
`default_nettype wire

// ### verification/dmr_host.sv
`timescale 1ns/100ps
`default_nettype none
module dmr_host (
  input  wire logic        core_clk,
  input  wire logic        acc_done,
  input  wire logic        acc_berr,
  input  wire logic [15:0] acc_rdata,
  output var  logic        acc_valid,
  output var  logic        acc_write,
  output var  logic        acc_super,
  output var  logic [11:0] acc_addr,
  output var  logic [1:0]  acc_byte_en,
  output var  logic [15:0] acc_wdata
);
  initial
  begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_super = 1'b0;
    acc_addr = 12'h000;
    acc_byte_en = 2'h3;
    acc_wdata = 16'h0000;
  end
  // Released address and data lines show inverted values so a stale bus never looks valid.
  task automatic xfer(input logic wr, input logic sup, input logic [11:0] a,
                      input logic [15:0] d, output logic [1:0] rsp, output logic [15:0] q);
    @(negedge core_clk);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_super = sup;
    acc_addr = a;
    acc_wdata = d;
    @(negedge core_clk);
    acc_valid = 1'b0;
    acc_super = 1'b0;
    acc_addr = ~a;
    acc_wdata = ~d;
    rsp = {acc_done, acc_berr};
    q = acc_rdata;
  endtask
endmodule // dmr_host
`default_nettype wire

// ### verification/dmr_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module dmr_regs_test;
  import dmr_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, cpu_reset_instr = 1'b0, freeze = 1'b0, iack_valid = 1'b0;
  logic bus_cycle_active = 1'b0, bus_cycle_end = 1'b0, data_drive_req = 1'b1, iack_win = 1'b1;
  logic [2:0]  bus_irq_level = 3'h0, cpu_priority_mask = 3'h0, iack_level = 3'h7;
  logic [1:0]  ch_bus_req = 2'h0, ch_single_addr = 2'h1, ch_irq_pending = 2'h0;
  logic        acc_valid, acc_write, acc_super, acc_done, acc_berr, module_clk_en;
  logic        bus_request_line, grant_ch2, data_bus_oe, iack_compete, iack_vec_valid;
  logic [11:0] acc_addr;
  logic [1:0]  acc_byte_en, su_access_ok, ch_start_ok, rsp;
  logic [15:0] acc_wdata, acc_rdata, q;
  logic [7:1]  irq_lines;
  logic [3:0]  iack_arb_id;
  logic [7:0]  iack_vector;
  int          bad_count = 0, tests_run = 0;
  always #5 core_clk = ~core_clk;
  dmr_regs i_dut (.*);
  dmr_host i_host (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    i_host.xfer(1'b1, 1'b1, a, d, rsp, q);
    chk(16'(rsp), 16'h0002);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    i_host.xfer(1'b0, 1'b1, a, 16'h0000, rsp, q);
    chk({rsp, q[13:0]}, {2'h2, exp[13:0]});
    chk(q, exp);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    give_verdict;
  end
  initial
  begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rd(12'h784, 16'h000F);
    rd(12'h7A4, 16'h000F);
    rd(12'h780, 16'h0080);
    wr(12'h780, 16'h7FFF);
    rd(12'h780, 16'h77FF);
    rd(12'h7A0, 16'h608F);
    i_host.xfer(1'b0, 1'b0, 12'h780, 16'h0000, rsp, q);
    chk(16'(rsp), 16'h0001);
    wr(12'h784, 16'hFFAB);
    rd(12'h784, 16'h07AB);
    ch_irq_pending = 2'b01;
    #1 chk(16'(irq_lines), 16'h0040);
    @(negedge core_clk);
    iack_valid = 1'b1;
    #1 chk(16'(iack_compete), 16'h0001);
    @(negedge core_clk);
    iack_valid = 1'b0;
    chk({iack_vec_valid, 7'h00, iack_vector}, 16'h80AB);
    // Both channels get the same priority id so the tie rule decides the grant.
    wr(12'h780, 16'h5321);
    wr(12'h7A0, 16'h4021);
    ch_bus_req = 2'b11;
    cpu_priority_mask = 3'h3;
    #1 chk(16'({bus_request_line, ch_start_ok}), 16'h0005);
    @(negedge core_clk);
    chk(16'({grant_ch2, data_bus_oe}), 16'h0001);
    // Channel 1 loses its drive enable so that dual-address mode has a bit to ignore.
    wr(12'h780, 16'h4321);
    #1 chk(16'(data_bus_oe), 16'h0000);
    ch_single_addr = 2'b00;
    #1 chk(16'(data_bus_oe), 16'h0001);
    ch_bus_req = 2'b10;
    @(negedge core_clk);
    chk(16'(grant_ch2), 16'h0001);
    bus_irq_level = 3'h1;
    #1 chk(16'(bus_request_line), 16'h0000);
    ch_bus_req = 2'b01;
    freeze = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(16'(bus_request_line), 16'h0000);
    freeze = 1'b0;
    // The frozen state is registered, so the request returns one edge after freeze falls.
    @(negedge core_clk);
    chk(16'({bus_request_line, su_access_ok}), 16'h0007);
    wr(12'h780, 16'hD321);
    chk(16'(module_clk_en), 16'h0000);
    i_host.xfer(1'b0, 1'b1, 12'h784, 16'h0000, rsp, q);
    chk(16'(rsp), 16'h0001);
    rd(12'h780, 16'hD321);
    wr(12'h780, 16'h5321);
    chk(16'(module_clk_en), 16'h0001);
    chk(16'(iack_arb_id), 16'h0001);
    cpu_reset_instr = 1'b1;
    @(negedge core_clk);
    cpu_reset_instr = 1'b0;
    rd(12'h784, 16'h000F);
    rd(12'h780, 16'h5321);
    wr(12'h784, 16'h0700);
    wr(12'h780, 16'h5320);
    iack_valid = 1'b1;
    #1 chk(16'(iack_compete), 16'h0000);
    @(negedge core_clk);
    iack_valid = 1'b0;
    give_verdict;
  end
endmodule // dmr_regs_test
bind dmr_regs dmr_regs_chk i_chk (.*);
`default_nettype wire
